// file: design/sdm_monitor.sv
// servo deviation monitor: deviation checks, overload alarms, avalon slave
//
// Behaviour
// R1 - after reset position and speed checks enabled, selector value 3
// R2 - selector bit value 1 runs position check, model versus measured position
// R3 - position deviation above limit raises position alarm and stops motor
// R4 - position limit accepts 1 to 1000 mm, resets to 50 mm
// R5 - selector bit value 2 runs speed check, model versus measured speed
// R6 - speed deviation above limit raises speed alarm and stops motor
// R7 - speed limit accepts 1 to 5000 mm/s, resets to 1000 mm/s
// R8 - selector bit value 4 runs thrust check, command versus feedback thrust
// R9 - thrust deviation above limit raises thrust alarm and stops motor
// R10 - thrust limit accepts 1 to 1000 percent, resets to 100 percent
// R11 - several checks may be enabled together, each works independently
// R12 - absolute, battery and counter alarms never raised for linear motor
// R13 - thermal overload alarm when accumulated load exceeds thermal curve
// R14 - peak current overload alarm when max current lasts several seconds
// R15 - full load current reference is 120 percent of rated current
// R16 - mass ratio equals load mass divided by primary side mass
// R17 - new selector takes effect only after power cycle or controller reset; here only controller reset loads it, rst_n_i restores value 3
// R18 - each deviation is absolute difference of the two quantities
// R19 - raised alarm held, motor stopped, until explicit alarm reset
`timescale 1ns/1ps
module sdm_monitor #(
  parameter int PEAK_CYCLES = sdm_pkg::PEAK_CYCLES   // peak current dwell count
) (
  input  wire logic        core_clk_i,               // 20 MHz clock
  input  wire logic        rst_n_i,                  // async reset, active low
  input  wire logic [7:0]  avs_address_i,            // byte address
  input  wire logic        avs_read_i,               // read request
  input  wire logic        avs_write_i,              // write request
  input  wire logic [31:0] avs_writedata_i,          // write data
  input  wire logic [3:0]  avs_byteenable_i,         // byte lanes
  output logic      [31:0] avs_readdata_o,           // read data
  output logic             avs_waitrequest_o,        // stall
  input  wire logic        sample_i,                 // new feedback sample valid
  input  wire logic [31:0] model_pos_i,              // model position, mm, signed
  input  wire logic [31:0] fb_pos_i,                 // measured position, mm
  input  wire logic [31:0] model_spd_i,              // model speed, mm/s
  input  wire logic [31:0] fb_spd_i,                 // measured speed, mm/s
  input  wire logic [31:0] cmd_thrust_i,             // command thrust, percent
  input  wire logic [31:0] fb_thrust_i,              // feedback thrust, percent
  input  wire logic [15:0] current_pct_i,            // motor current, % of rated
  output logic             motor_stop_o,             // stop the linear motor
  output logic [4:0]       alarm_o,                  // latched alarm set
  output logic             absolute_lost_alarm_o,    // never raised
  output logic             battery_cable_warning_o,  // never raised
  output logic             battery_low_warning_o,    // never raised
  output logic             absolute_counter_warning_o, // never raised
  output logic             irq_o                     // level interrupt
);

  typedef struct packed {
    logic [2:0]          sel_pending;
    logic [2:0]          sel_active;
    logic [15:0]         pos_lim;
    logic [15:0]         spd_lim;
    logic [15:0]         thr_lim;
    logic [4:0]          alarm;
    logic [4:0]          status;
    logic [4:0]          mask;
    logic [31:0]         heat;
    logic [31:0]         peak_cnt;
    logic [15:0]         load_mass;
    logic [15:0]         prim_mass;
    logic [15:0]         ratio;
    logic [15:0]         div_rem;
    logic [15:0]         div_quo;
    logic [4:0]          div_cnt;
    sdm_pkg::sdm_div_t   div_st;
    logic [31:0]         rdata;
    logic                wait_n;
    logic                stop;
    logic                irq;
  } sdm_state_t;

  sdm_state_t s_r;
  sdm_state_t s_nxt;

  // absolute difference of two signed quantities
  function automatic logic [32:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
    logic signed [32:0] d;
    d = $signed({a[31], a}) - $signed({b[31], b});
    abs_diff = d[32] ? 33'(-d) : 33'(d);
  endfunction : abs_diff

  // keep a limit inside its legal range
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  logic [32:0] pos_dev;
  logic [32:0] spd_dev;
  logic [32:0] thr_dev;
  logic [15:0] full_load;
  logic        acc;
  logic        wr;
  logic [4:0]  ev;

  assign acc = (avs_read_i | avs_write_i) & ~s_r.wait_n;
  assign wr  = avs_write_i & ~s_r.wait_n & avs_byteenable_i[0];

  // combinational next state
  always_comb begin
    s_nxt   = s_r;
    pos_dev = abs_diff(model_pos_i, fb_pos_i);                 // R18
    spd_dev = abs_diff(model_spd_i, fb_spd_i);                 // R18
    thr_dev = abs_diff(cmd_thrust_i, fb_thrust_i);             // R18
    full_load = 16'((32'(sdm_pkg::FULL_LOAD_PCT)) );           // R15
    ev = '0;
    // each check gated by its own selector bit
    if (sample_i) begin
      ev[sdm_pkg::AL_POS] = s_r.sel_active[sdm_pkg::SEL_POS_BIT]
                            & (pos_dev > 33'(s_r.pos_lim));   // R2 R3 R11
      ev[sdm_pkg::AL_SPD] = s_r.sel_active[sdm_pkg::SEL_SPD_BIT]
                            & (spd_dev > 33'(s_r.spd_lim));   // R5 R6 R11
      ev[sdm_pkg::AL_THR] = s_r.sel_active[sdm_pkg::SEL_THR_BIT]
                            & (thr_dev > 33'(s_r.thr_lim));   // R8 R9 R11
    end
    // thermal integrator: heats above full load, cools below
    if (current_pct_i > full_load) begin
      s_nxt.heat = s_r.heat + 32'(current_pct_i - full_load);       // R13
    end else if (s_r.heat > 32'(full_load - current_pct_i)) begin
      s_nxt.heat = s_r.heat - 32'(full_load - current_pct_i);
    end else begin
      s_nxt.heat = sdm_pkg::DATA_ZERO;
    end
    if (s_r.heat >= sdm_pkg::THERM_TRIP) begin
      ev[sdm_pkg::AL_THRM] = 1'b1;                                  // R13
    end
    // peak current dwell, restarts whenever current drops
    if (current_pct_i >= sdm_pkg::PEAK_PCT) begin
      if (s_r.peak_cnt >= 32'(PEAK_CYCLES - 1)) begin
        ev[sdm_pkg::AL_PEAK] = 1'b1;                                // R14
      end else begin
        s_nxt.peak_cnt = s_r.peak_cnt + 32'h0000_0001;
      end
    end else begin
      s_nxt.peak_cnt = sdm_pkg::DATA_ZERO;
    end
    // mass ratio divider, one quotient bit per cycle
    unique case (s_r.div_st)
      sdm_pkg::DIV_IDLE: begin
        if (s_r.prim_mass != 16'h0000) begin
          s_nxt.div_rem = 16'h0000;
          s_nxt.div_quo = s_r.load_mass;
          s_nxt.div_cnt = 5'h10;
          s_nxt.div_st  = sdm_pkg::DIV_RUN;
        end
      end
      sdm_pkg::DIV_RUN: begin
        // compare on 17 bits, a large divisor leaves a remainder with bit 15 set
        if ({s_r.div_rem, s_r.div_quo[15]} >= {1'b0, s_r.prim_mass}) begin
          s_nxt.div_rem = 16'({s_r.div_rem, s_r.div_quo[15]} - {1'b0, s_r.prim_mass});
          s_nxt.div_quo = {s_r.div_quo[14:0], 1'b1};
        end else begin
          s_nxt.div_rem = {s_r.div_rem[14:0], s_r.div_quo[15]};
          s_nxt.div_quo = {s_r.div_quo[14:0], 1'b0};
        end
        s_nxt.div_cnt = s_r.div_cnt - 5'h01;
        if (s_r.div_cnt == 5'h01) begin
          s_nxt.div_st = sdm_pkg::DIV_DONE;
        end
      end
      sdm_pkg::DIV_DONE: begin
        s_nxt.ratio  = s_r.div_quo;                                 // R16
        s_nxt.div_st = sdm_pkg::DIV_IDLE;
      end
      default: begin
        s_nxt.div_st = sdm_pkg::DIV_IDLE;
      end
    endcase
    // bus: one wait cycle, answer on the second
    s_nxt.wait_n = acc;
    s_nxt.rdata  = sdm_pkg::DATA_ZERO;
    if (avs_read_i & ~s_r.wait_n) begin
      unique case (avs_address_i)
        sdm_pkg::OFS_SELECT:     s_nxt.rdata = {29'h0, s_r.sel_pending};
        sdm_pkg::OFS_POS_LIMIT:  s_nxt.rdata = {16'h0, s_r.pos_lim};
        sdm_pkg::OFS_SPD_LIMIT:  s_nxt.rdata = {16'h0, s_r.spd_lim};
        sdm_pkg::OFS_THR_LIMIT:  s_nxt.rdata = {16'h0, s_r.thr_lim};
        sdm_pkg::OFS_STATUS:     s_nxt.rdata = {27'h0, s_r.status};
        sdm_pkg::OFS_MASK:       s_nxt.rdata = {27'h0, s_r.mask};
        sdm_pkg::OFS_ALARMS:     s_nxt.rdata = {24'h0, s_r.sel_active, s_r.alarm};
        sdm_pkg::OFS_MASS_RATIO: s_nxt.rdata = {16'h0, s_r.ratio};
        sdm_pkg::OFS_LOAD_MASS:  s_nxt.rdata = {16'h0, s_r.load_mass};
        sdm_pkg::OFS_PRIM_MASS:  s_nxt.rdata = {16'h0, s_r.prim_mass};
        default:                 s_nxt.rdata = sdm_pkg::DATA_ZERO;
      endcase
    end
    // clear-on-one status write, event set wins
    if (wr && avs_address_i == sdm_pkg::OFS_STATUS) begin
      s_nxt.status = s_r.status & ~avs_writedata_i[4:0];
    end
    s_nxt.status = s_nxt.status | ev;
    // explicit alarm reset drops held alarms before new events latch
    if (wr && avs_address_i == sdm_pkg::OFS_CONTROL
        && avs_writedata_i[sdm_pkg::CTL_ALARM_RESET]) begin
      s_nxt.alarm = '0;                                             // R19
    end
    // controller reset loads the pending selector
    if (wr && avs_address_i == sdm_pkg::OFS_CONTROL
        && avs_writedata_i[sdm_pkg::CTL_CTRL_RESET]) begin
      s_nxt.sel_active = s_r.sel_pending;                           // R17
    end
    s_nxt.alarm = s_nxt.alarm | ev;                                 // R19
    if (wr) begin
      unique case (avs_address_i)
        sdm_pkg::OFS_SELECT:    s_nxt.sel_pending = avs_writedata_i[2:0];  // R17
        sdm_pkg::OFS_POS_LIMIT: s_nxt.pos_lim = clamp(avs_writedata_i[15:0],
                                  sdm_pkg::POS_LIM_MIN, sdm_pkg::POS_LIM_MAX); // R4
        sdm_pkg::OFS_SPD_LIMIT: s_nxt.spd_lim = clamp(avs_writedata_i[15:0],
                                  sdm_pkg::SPD_LIM_MIN, sdm_pkg::SPD_LIM_MAX); // R7
        sdm_pkg::OFS_THR_LIMIT: s_nxt.thr_lim = clamp(avs_writedata_i[15:0],
                                  sdm_pkg::THR_LIM_MIN, sdm_pkg::THR_LIM_MAX); // R10
        sdm_pkg::OFS_MASK:      s_nxt.mask = avs_writedata_i[4:0];
        sdm_pkg::OFS_LOAD_MASS: s_nxt.load_mass = avs_writedata_i[15:0];
        sdm_pkg::OFS_PRIM_MASS: s_nxt.prim_mass = avs_writedata_i[15:0];
        default: ;
      endcase
    end
    s_nxt.stop = |s_nxt.alarm;                                      // R3 R6 R9 R19
    s_nxt.irq  = |(s_nxt.status & s_nxt.mask);
  end

  // single state register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r             <= '0;
      s_r.sel_pending <= sdm_pkg::SEL_RESET;                        // R1
      s_r.sel_active  <= sdm_pkg::SEL_RESET;                        // R1
      s_r.pos_lim     <= sdm_pkg::POS_LIM_RST;                      // R4
      s_r.spd_lim     <= sdm_pkg::SPD_LIM_RST;                      // R7
      s_r.thr_lim     <= sdm_pkg::THR_LIM_RST;                      // R10
      s_r.div_st      <= sdm_pkg::DIV_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign avs_readdata_o             = s_r.rdata;
  assign avs_waitrequest_o          = ~s_r.wait_n;
  assign motor_stop_o               = s_r.stop;
  assign alarm_o                    = s_r.alarm;
  assign irq_o                      = s_r.irq;
  // linear motor has no battery backed absolute encoder here
  assign absolute_lost_alarm_o      = s_r.wait_n & 1'b0;            // R12
  assign battery_cable_warning_o    = s_r.wait_n & 1'b0;            // R12
  assign battery_low_warning_o      = s_r.wait_n & 1'b0;            // R12
  assign absolute_counter_warning_o = s_r.wait_n & 1'b0;            // R12

endmodule : sdm_monitor

// file: design/sdm_pkg.sv
// constants, register map and types for the servo deviation monitor
package sdm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_SELECT     = 8'h00;
  localparam logic [7:0] OFS_POS_LIMIT  = 8'h04;
  localparam logic [7:0] OFS_SPD_LIMIT  = 8'h08;
  localparam logic [7:0] OFS_THR_LIMIT  = 8'h0C;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  localparam logic [7:0] OFS_MASK       = 8'h14;
  localparam logic [7:0] OFS_CONTROL    = 8'h18;
  localparam logic [7:0] OFS_ALARMS     = 8'h1C;
  localparam logic [7:0] OFS_MASS_RATIO = 8'h20;
  localparam logic [7:0] OFS_LOAD_MASS  = 8'h24;
  localparam logic [7:0] OFS_PRIM_MASS  = 8'h28;
  // selector bits and reset value
  localparam int          SEL_POS_BIT = 0;
  localparam int          SEL_SPD_BIT = 1;
  localparam int          SEL_THR_BIT = 2;
  localparam logic [2:0]  SEL_RESET   = 3'h3;
  // limits: reset, min, max (mm, mm/s, percent)
  localparam logic [15:0] POS_LIM_RST = 16'h0032;
  localparam logic [15:0] POS_LIM_MIN = 16'h0001;
  localparam logic [15:0] POS_LIM_MAX = 16'h03E8;
  localparam logic [15:0] SPD_LIM_RST = 16'h03E8;
  localparam logic [15:0] SPD_LIM_MIN = 16'h0001;
  localparam logic [15:0] SPD_LIM_MAX = 16'h1388;
  localparam logic [15:0] THR_LIM_RST = 16'h0064;
  localparam logic [15:0] THR_LIM_MIN = 16'h0001;
  localparam logic [15:0] THR_LIM_MAX = 16'h03E8;
  // alarm bit positions in status, mask and alarm registers
  localparam int AL_POS  = 0;
  localparam int AL_SPD  = 1;
  localparam int AL_THR  = 2;
  localparam int AL_THRM = 3;
  localparam int AL_PEAK = 4;
  localparam int AL_W    = 5;
  // control bits
  localparam int CTL_ALARM_RESET = 0;
  localparam int CTL_CTRL_RESET  = 1;
  // thermal model: full load is 120 percent of rated current
  localparam logic [15:0] FULL_LOAD_PCT = 16'h0078;
  localparam logic [31:0] THERM_TRIP    = 32'h0100_0000;
  localparam logic [15:0] PEAK_PCT      = 16'h012C;
  localparam int          PEAK_TIME_MS  = 3000;
  localparam int          CLK_KHZ       = 20000;
  localparam int          PEAK_CYCLES   = PEAK_TIME_MS * CLK_KHZ;
  localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;
  // divider state
  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_RUN  = 2'b01,
    DIV_DONE = 2'b10
  } sdm_div_t;
endpackage : sdm_pkg

// file: verification/sdm_loop_model.sv
// servo loop model: turns requested deviations into model and feedback pairs
`timescale 1ns/1ps
module sdm_loop_model (
  input  wire logic        clk_i,    // core clock
  input  wire logic        go_i,     // present one sample
  input  wire logic [31:0] dp_i,     // position deviation
  input  wire logic [31:0] ds_i,     // speed deviation
  input  wire logic [31:0] dt_i,     // thrust deviation
  output logic             sample_o, // sample valid, one cycle
  output logic [31:0]      mp_o,     // model position
  output logic [31:0]      fp_o,     // measured position
  output logic [31:0]      ms_o,     // model speed
  output logic [31:0]      fs_o,     // measured speed
  output logic [31:0]      ct_o,     // command thrust
  output logic [31:0]      ft_o      // feedback thrust
);
  // base moves every cycle, so a monitor that ignores the difference is caught
  logic [31:0] base_r = 32'h0000_1000;
  always @(posedge clk_i) begin
    base_r   <= base_r + 32'h0000_0101;
    sample_o <= go_i;
    fp_o     <= base_r;
    mp_o     <= base_r + dp_i;
    fs_o     <= base_r;
    ms_o     <= base_r + ds_i;
    ft_o     <= base_r;
    ct_o     <= base_r + dt_i;
  end
endmodule : sdm_loop_model

// file: verification/sdm_monitor_props.sv
// port checker for the deviation monitor
`timescale 1ns/1ps
module sdm_monitor_props #(
  parameter int PEAK_CYCLES = 100 // peak current dwell count
) (
  input wire logic        core_clk_i,                 // clock
  input wire logic        rst_n_i,                    // reset, active low
  input wire logic [7:0]  avs_address_i,              // address
  input wire logic        avs_read_i,                 // read
  input wire logic        avs_write_i,                // write
  input wire logic [31:0] avs_writedata_i,            // write data
  input wire logic [31:0] avs_readdata_o,             // read data
  input wire logic        avs_waitrequest_o,          // stall
  input wire logic        sample_i,                   // sample valid
  input wire logic [15:0] current_pct_i,              // motor current
  input wire logic        motor_stop_o,               // stop
  input wire logic [4:0]  alarm_o,                    // held alarms
  input wire logic        absolute_lost_alarm_o,      // never raised
  input wire logic        battery_cable_warning_o,    // never raised
  input wire logic        battery_low_warning_o,      // never raised
  input wire logic        absolute_counter_warning_o  // never raised
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // alarm reset request and run length of peak current
  wire clr = avs_write_i && avs_address_i == sdm_pkg::OFS_CONTROL && avs_writedata_i[0];
  int  run_r;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) run_r <= 0;
    else run_r <= (current_pct_i >= sdm_pkg::PEAK_PCT) ? run_r + 1 : 0;
  end
  sequence s_take; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_ans; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  property p_answer; s_take |=> s_ans; endproperty
  property p_idle_zero; avs_waitrequest_o |-> avs_readdata_o == 32'h0000_0000; endproperty
  property p_never; !(absolute_lost_alarm_o || battery_cable_warning_o
    || battery_low_warning_o || absolute_counter_warning_o); endproperty
  property p_stop; motor_stop_o == (alarm_o != 5'h00); endproperty
  property p_hold; |($past(alarm_o) & ~alarm_o) |-> $past(clr) || $past(clr, 2); endproperty
  property p_pos; $rose(alarm_o[sdm_pkg::AL_POS]) |-> $past(sample_i); endproperty
  property p_spd; $rose(alarm_o[sdm_pkg::AL_SPD]) |-> $past(sample_i); endproperty
  property p_thr; $rose(alarm_o[sdm_pkg::AL_THR]) |-> $past(sample_i); endproperty
  property p_therm; $rose(alarm_o[sdm_pkg::AL_THRM]) |->
    $past(current_pct_i > sdm_pkg::FULL_LOAD_PCT) || $past(current_pct_i > 16'h0078, 2);
  endproperty
  property p_peak; $rose(alarm_o[sdm_pkg::AL_PEAK]) |-> run_r >= PEAK_CYCLES; endproperty
  a_answer: assert property (p_answer) else $error("bus answer timing wrong");
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero at idle");
  a_never: assert property (p_never) else $error("absolute or battery alarm raised");
  a_stop: assert property (p_stop) else $error("motor stop not tied to alarms");
  a_hold: assert property (p_hold) else $error("alarm dropped without reset");
  a_pos: assert property (p_pos) else $error("position alarm without sample");
  a_spd: assert property (p_spd) else $error("speed alarm without sample");
  a_thr: assert property (p_thr) else $error("thrust alarm without sample");
  a_therm: assert property (p_therm) else $error("thermal alarm below full load");
  a_peak: assert property (p_peak) else $error("peak alarm too early");
endmodule : sdm_monitor_props
bind sdm_monitor sdm_monitor_props #(.PEAK_CYCLES(PEAK_CYCLES)) u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .sample_i(sample_i), .current_pct_i(current_pct_i), .motor_stop_o(motor_stop_o),
  .alarm_o(alarm_o), .absolute_lost_alarm_o(absolute_lost_alarm_o),
  .battery_cable_warning_o(battery_cable_warning_o),
  .battery_low_warning_o(battery_low_warning_o),
  .absolute_counter_warning_o(absolute_counter_warning_o));

// file: verification/sdm_monitor_tb.sv
// self-checking bench for the deviation monitor
`timescale 1ns/1ps
module sdm_monitor_tb;
  typedef struct { logic [31:0] p, s, t; logic [4:0] al; } sdm_row_t;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = '0, dp = '0, ds = '0, dt = '0, q, mp, fp, ms, fs, ct, ft, rdo;
  logic [15:0] cur = 16'h0000;
  logic [3:0]  be = 4'hF;
  logic        smp, wt, stop, irq, n0, n1, n2, n3;
  logic [4:0]  al;
  int          bad_count = 0, tests_run = 0, cyc = 0;
  // position and speed only at reset, thrust rows must stay quiet
  sdm_row_t rows [6] = '{'{32'h0000_0032, '0, '0, 5'h00}, '{32'h0000_0033, '0, '0, 5'h01},
    '{-32'h0000_0033, '0, '0, 5'h01}, '{'0, 32'h0000_03E8, '0, 5'h00},
    '{'0, -32'h0000_03E9, '0, 5'h02}, '{'0, '0, 32'h0000_00C8, 5'h00}};
  always #25 core_clk_i = ~core_clk_i;
  sdm_loop_model u_loop (.clk_i(core_clk_i), .go_i(go), .dp_i(dp), .ds_i(ds), .dt_i(dt),
    .sample_o(smp), .mp_o(mp), .fp_o(fp), .ms_o(ms), .fs_o(fs), .ct_o(ct), .ft_o(ft));
  sdm_monitor #(.PEAK_CYCLES(100)) uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdo), .avs_waitrequest_o(wt),
    .sample_i(smp), .model_pos_i(mp), .fb_pos_i(fp), .model_spd_i(ms), .fb_spd_i(fs),
    .cmd_thrust_i(ct), .fb_thrust_i(ft), .current_pct_i(cur), .motor_stop_o(stop),
    .alarm_o(al), .absolute_lost_alarm_o(n0), .battery_cable_warning_o(n1),
    .battery_low_warning_o(n2), .absolute_counter_warning_o(n3), .irq_o(irq));
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // hang guard, the whole run needs about 1300 cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      print_verdict;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task chk_bit(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : chk_bit
  // held until the rising edge that samples waitrequest low, data taken there
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    @(posedge core_clk_i);
    while (wt !== 1'b0) @(posedge core_clk_i);
    q = rdo;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task dev(input logic [31:0] p, input logic [31:0] s, input logic [31:0] t);
    @(posedge core_clk_i);
    go <= 1'b1;
    dp <= p;
    ds <= s;
    dt <= t;
    @(posedge core_clk_i);
    go <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : dev
  task run_cur(input logic [15:0] c, input int n);
    @(posedge core_clk_i);
    cur <= c;
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : run_cur
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, sdm_pkg::OFS_SELECT, '0); chk("select", 32'h0000_0003, q);
    bus(1'b0, sdm_pkg::OFS_POS_LIMIT, '0); chk("pos_lim", 32'h0000_0032, q);
    bus(1'b0, sdm_pkg::OFS_SPD_LIMIT, '0); chk("spd_lim", 32'h0000_03E8, q);
    bus(1'b0, sdm_pkg::OFS_THR_LIMIT, '0); chk("thr_lim", 32'h0000_0064, q);
    bus(1'b0, 8'h3C, '0); chk("unmapped", 32'h0000_0000, q);
    chk_bit("never", 1'b0, n0 | n1 | n2 | n3);
    // table rows: deviation at, above and below the limits, then reset
    for (int i = 0; i < 6; i++) begin
      dev(rows[i].p, rows[i].s, rows[i].t);
      chk("alarm", {27'h0, rows[i].al}, {27'h0, al});
      chk_bit("stop", |rows[i].al, stop);
      bus(1'b1, sdm_pkg::OFS_CONTROL, 32'h0000_0001);
      chk("cleared", 32'h0000_0000, {27'h0, al});
    end
    // selector waits for the controller reset
    bus(1'b1, sdm_pkg::OFS_SELECT, 32'h0000_0004);
    dev('0, '0, 32'h0000_0065); chk("pending", 32'h0000_0000, {27'h0, al});
    bus(1'b1, sdm_pkg::OFS_CONTROL, 32'h0000_0002);
    dev('0, '0, 32'h0000_0065); chk("thrust", 32'h0000_0004, {27'h0, al});
    bus(1'b1, sdm_pkg::OFS_SELECT, 32'h0000_0007);
    bus(1'b1, sdm_pkg::OFS_CONTROL, 32'h0000_0003);
    dev(32'h0000_0033, 32'h0000_03E9, 32'h0000_0065);
    bus(1'b0, sdm_pkg::OFS_ALARMS, '0); chk("alarms", 32'h0000_00E7, q);
    // interrupt: raised when unmasked, cleared by reset plus one written to status
    bus(1'b1, sdm_pkg::OFS_CONTROL, 32'h0000_0001);
    bus(1'b1, sdm_pkg::OFS_STATUS, 32'h0000_001F);
    bus(1'b1, sdm_pkg::OFS_MASK, 32'h0000_0001);
    dev(32'h0000_0033, '0, '0); chk_bit("irq", 1'b1, irq);
    bus(1'b0, sdm_pkg::OFS_STATUS, '0); chk("status", 32'h0000_0001, q);
    bus(1'b1, sdm_pkg::OFS_CONTROL, 32'h0000_0001);
    bus(1'b1, sdm_pkg::OFS_STATUS, 32'h0000_0001); chk_bit("irq_clr", 1'b0, irq);
    bus(1'b1, sdm_pkg::OFS_MASK, '0);
    dev(32'h0000_0033, '0, '0); chk_bit("irq_mask", 1'b0, irq);
    bus(1'b1, sdm_pkg::OFS_CONTROL, 32'h0000_0001);
    // limit writes are clamped into range
    bus(1'b1, sdm_pkg::OFS_POS_LIMIT, '0);
    bus(1'b0, sdm_pkg::OFS_POS_LIMIT, '0); chk("pos_min", 32'h0000_0001, q);
    bus(1'b1, sdm_pkg::OFS_POS_LIMIT, 32'h0000_07D0);
    bus(1'b0, sdm_pkg::OFS_POS_LIMIT, '0); chk("pos_max", 32'h0000_03E8, q);
    bus(1'b1, sdm_pkg::OFS_SPD_LIMIT, 32'h0000_1770);
    bus(1'b0, sdm_pkg::OFS_SPD_LIMIT, '0); chk("spd_max", 32'h0000_1388, q);
    bus(1'b1, sdm_pkg::OFS_THR_LIMIT, 32'h0000_2710);
    bus(1'b0, sdm_pkg::OFS_THR_LIMIT, '0); chk("thr_max", 32'h0000_03E8, q);
    // lane 0 off: the write must be ignored
    be <= 4'hE;
    bus(1'b1, sdm_pkg::OFS_THR_LIMIT, 32'h0000_0005);
    be <= 4'hF;
    bus(1'b0, sdm_pkg::OFS_THR_LIMIT, '0); chk("lane_off", 32'h0000_03E8, q);
    // mass ratio, fixed wait covers the 18 cycle division
    bus(1'b1, sdm_pkg::OFS_LOAD_MASS, 32'h0000_0004);
    bus(1'b1, sdm_pkg::OFS_PRIM_MASS, 32'h0000_0002);
    repeat (40) @(posedge core_clk_i);
    bus(1'b0, sdm_pkg::OFS_MASS_RATIO, '0); chk("ratio", 32'h0000_0002, q);
    // peak current: just below never trips, at the level trips after the dwell
    run_cur(16'h012B, 150); chk("below_peak", 32'h0000_0000, {27'h0, al});
    run_cur(16'h0078, 300); chk_bit("full_load", 1'b0, al[3]);
    run_cur(16'h012C, 120); chk_bit("peak", 1'b1, al[4]);
    run_cur(16'hFFFF, 400); chk_bit("thermal", 1'b1, al[3]);
    // second reset in mid-run restores defaults
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    cur <= 16'h0000;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, sdm_pkg::OFS_SELECT, '0); chk("select_again", 32'h0000_0003, q);
    chk("alarm_again", 32'h0000_0000, {27'h0, al});
    print_verdict;
  end
endmodule : sdm_monitor_tb
